// [inc/ufi_defines.svh]
// Register offsets, field positions, reset values and counts for the UART core
`ifndef UFI_DEFINES_SVH
`define UFI_DEFINES_SVH
`define UFI_A_DATA 3'h0
`define UFI_A_IER 3'h1
`define UFI_A_FCR 3'h2
`define UFI_A_LCR 3'h3
`define UFI_A_MCR 3'h4
`define UFI_A_LSR 3'h5
`define UFI_A_MSR 3'h6
`define UFI_A_SPR 3'h7
`define UFI_A_EFR 3'h2
`define UFI_A_RES1 3'h4
`define UFI_A_RES2 3'h5
`define UFI_A_PAU1 3'h6
`define UFI_A_PAU2 3'h7
`define UFI_LCR_ENH 8'hbf
`define UFI_LCR_DLAB 7
`define UFI_FCR_EN 0
`define UFI_FCR_RXCLR 1
`define UFI_FCR_TXCLR 2
`define UFI_FCR_DMA 3
`define UFI_EFR_ENH 4
`define UFI_IER_RX 0
`define UFI_IER_TX 1
`define UFI_IER_LS 2
`define UFI_IER_MS 3
`define UFI_IER_PAUSE 5
`define UFI_IER_RTS 6
`define UFI_IER_CTS 7
`define UFI_RST_SPR 8'hff
`define UFI_RST_FCR 8'h00
`define UFI_DEPTH 5'h10
`define UFI_START_TICKS 4'h7
`define UFI_BIT_TICKS 4'hf
`define UFI_ISR_LS 6'h06
`define UFI_ISR_RX 6'h04
`define UFI_ISR_TX 6'h02
`define UFI_ISR_MS 6'h00
`define UFI_ISR_PAUSE 6'h10
`define UFI_ISR_FC 6'h20
`define UFI_ISR_NONE 6'h01
`endif

// [inc/ufi_pkg.sv]
// Types shared by the UART core: states, bus carrier and full state record
`include "ufi_defines.svh"
package ufi_pkg;
  typedef enum logic [3:0] {
    UFI_IDLE = 4'h1,
    UFI_START = 4'h2,
    UFI_DATA = 4'h4,
    UFI_STOP = 4'h8
  } ufi_ser_state_type;

  typedef struct packed {
    logic cs;
    logic rd;
    logic wr;
    logic [2:0] addr;
    logic [7:0] wdata;
  } ufi_bus_type;

  typedef struct packed {
    logic [7:0] line_ctrl_reg, int_enable_reg, fifo_ctrl_reg, enhanced_feature_reg, modem_ctrl_reg, spr, dll, dlm;
    logic [7:0] res1, res2, pau1, pau2;
    logic [15:0] div_cnt;
    logic rx_s1, rx_s2, rx_prev;
    logic [1:0] mdm_s1, mdm_s2, mdm_prev;
    ufi_ser_state_type rx_st, tx_st;
    logic [3:0] rx_tick, tx_tick;
    logic [2:0] rx_bit, tx_bit;
    logic [7:0] rx_sr, tx_sr;
    logic [15:0][7:0] rx_mem, tx_mem;
    logic [3:0] rx_rp, rx_wp, tx_rp, tx_wp;
    logic [4:0] rx_cnt, tx_cnt;
    logic oe, fe, bi, dcts, pause_hit, rts_rise, cts_rise, tx_ack, rx_dma;
    logic [7:0] rdata;
    logic tx_line, irq, tx_dma_n, rx_dma_n;
  } ufi_state_type;

  function automatic ufi_state_type ufi_init();
    ufi_init = '0;
    ufi_init.spr = `UFI_RST_SPR;
    ufi_init.rx_s1 = 1'b1;
    ufi_init.rx_s2 = 1'b1;
    ufi_init.rx_prev = 1'b1;
    ufi_init.rx_st = UFI_IDLE;
    ufi_init.tx_st = UFI_IDLE;
    ufi_init.tx_line = 1'b1;
    ufi_init.tx_dma_n = 1'b1;
    ufi_init.rx_dma_n = 1'b1;
  endfunction
endpackage

// [core/ufi_core.sv]
// UART core: register access, FIFOs, start-bit check, interrupts and DMA
//
// Summary of operation
// - Divisor latch registers are selected only while line control bit 7 is set.
// - Enhanced and flow character registers are selected only when line control is 0xBF.
// - A transmit holding write stores the data byte if there is room.
// - Holding-empty status is set when transmitter empty or a byte moves to shifter.
// - Receive holding read returns the oldest byte and removes it.
// - After a line fall, sample at 7.5 sample clocks; accept only if low.
// - Interrupt enable bits gate receive, transmit, line and modem sources.
// - Receive interrupt rises at trigger fill and drops below it.
// - Identity register shows the trigger condition; clears with the interrupt.
// - Data-ready is set on each receive push and cleared when FIFO empties.
// - Line status reports data, errors, transmit empties and FIFO error.
// - Enable bits 0-3 select four basic interrupts; all reset to zero.
// - Enable bit 4 (sleep) is stored but has no effect, bit 5 the pause-character interrupt; reset zero.
// - Enable bits 6 and 7 interrupt on rising request or clear to send.
// - Mode 0: transmit request low when holding is empty, receive when loaded.
// - Mode 1: transmit interrupt below trigger; request low while space remains.
// - Mode 1: receive interrupt at trigger; request low from trigger until empty.
// - FIFO enable bit gates programming of all other FIFO control bits.
// - Receive FIFO clear bit empties it, leaves shifter, and self-clears.
// - Transmit FIFO clear bit empties it, leaves shifter, and self-clears.
// - FIFO control bit 3 picks DMA mode 0 or 1.
// - Transmit trigger is 1, 4, 8 or 14; interrupt when count falls below.
// - Receive trigger is 1, 4, 8 or 14; interrupt when count reaches it.
`timescale 1ns/1ps
`include "ufi_defines.svh"
module ufi_core (
  input wire logic clk,
  input wire logic arst_n,
  input wire ufi_pkg::ufi_bus_type bus,
  input wire logic rx_in,
  input wire logic rts_in,
  input wire logic cts_in,
  output logic [7:0] rdata,
  output logic tx_out,
  output logic irq_out,
  output logic tx_dma_request_n,
  output logic rx_dma_request_n
);
  ufi_pkg::ufi_state_type s;
  ufi_pkg::ufi_state_type n;
  logic [1:0] rst_q;

  // Trigger field to character count
  function automatic logic [4:0] trig_level(input logic [1:0] f);
    case (f)
      2'h0: trig_level = 5'h01;
      2'h1: trig_level = 5'h04;
      2'h2: trig_level = 5'h08;
      default: trig_level = 5'h0e;
    endcase
  endfunction

  // Reset is released through two flops so the release is glitch free
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_q <= 2'h0;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end

  always_comb begin
    logic [15:0] dl;
    logic tick, rxd, half, fifo_en, enh, dlab, wr, rd;
    logic push_rx, pop_rx, push_tx, pop_tx, rx_clr, tx_clr;
    logic tx_low, rx_trig, ls_p, rx_p, tx_p, ms_p, pa_p, fc_p;
    logic [4:0] depth, rtrig, ttrig;
    logic [7:0] rx_byte, line_status_reg;
    logic [5:0] code;
    dl = '0;
    tick = 1'b0;
    rxd = 1'b1;
    half = 1'b0;
    fifo_en = 1'b0;
    enh = 1'b0;
    dlab = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    push_rx = 1'b0;
    pop_rx = 1'b0;
    push_tx = 1'b0;
    pop_tx = 1'b0;
    rx_clr = 1'b0;
    tx_clr = 1'b0;
    tx_low = 1'b0;
    rx_trig = 1'b0;
    ls_p = 1'b0;
    rx_p = 1'b0;
    tx_p = 1'b0;
    ms_p = 1'b0;
    pa_p = 1'b0;
    fc_p = 1'b0;
    depth = '0;
    rtrig = '0;
    ttrig = '0;
    rx_byte = '0;
    line_status_reg = '0;
    code = `UFI_ISR_NONE;
    n = s;

    // Sample-clock divider; a zero divisor behaves as one
    dl = {s.dlm, s.dll};
    if (dl == 16'h0000) begin
      dl = 16'h0001;
    end
    half = (s.div_cnt == {1'b0, dl[15:1]});
    if (s.div_cnt >= dl - 16'h0001) begin
      n.div_cnt = '0;
      tick = 1'b1;
    end else begin
      n.div_cnt = s.div_cnt + 16'h0001;
    end

    // Pin synchronisers; only the second stage is looked at
    n.rx_s1 = rx_in;
    n.rx_s2 = s.rx_s1;
    n.mdm_s1 = {cts_in, rts_in};
    n.mdm_s2 = s.mdm_s1;
    n.mdm_prev = s.mdm_s2;
    rxd = s.rx_s2;
    n.rx_prev = rxd;

    fifo_en = s.fifo_ctrl_reg[`UFI_FCR_EN];
    depth = fifo_en ? `UFI_DEPTH : 5'h01;
    rtrig = fifo_en ? trig_level(s.fifo_ctrl_reg[7:6]) : 5'h01;
    ttrig = fifo_en ? trig_level(s.fifo_ctrl_reg[5:4]) : 5'h01;
    enh = (s.line_ctrl_reg == `UFI_LCR_ENH);
    dlab = s.line_ctrl_reg[`UFI_LCR_DLAB];
    wr = bus.cs & bus.wr;
    rd = bus.cs & bus.rd;

    // Interrupt sources
    // transmit below trigger
    tx_low = (s.tx_cnt < ttrig);
    rx_trig = (s.rx_cnt >= rtrig);
    ls_p = s.int_enable_reg[`UFI_IER_LS] & (s.oe | s.fe | s.bi);
    rx_p = s.int_enable_reg[`UFI_IER_RX] & rx_trig;
    tx_p = s.int_enable_reg[`UFI_IER_TX] & tx_low & ~s.tx_ack;
    ms_p = s.int_enable_reg[`UFI_IER_MS] & s.dcts;
    pa_p = s.int_enable_reg[`UFI_IER_PAUSE] & s.enhanced_feature_reg[`UFI_EFR_ENH] & s.pause_hit;
    // rising request or clear to send
    fc_p = s.enhanced_feature_reg[`UFI_EFR_ENH] &
      ((s.int_enable_reg[`UFI_IER_RTS] & s.rts_rise) |
       (s.int_enable_reg[`UFI_IER_CTS] & s.cts_rise));
    if (ls_p) begin
      code = `UFI_ISR_LS;
    end else if (rx_p) begin
      code = `UFI_ISR_RX;
    end else if (tx_p) begin
      code = `UFI_ISR_TX;
    end else if (ms_p) begin
      code = `UFI_ISR_MS;
    end else if (pa_p) begin
      code = `UFI_ISR_PAUSE;
    end else if (fc_p) begin
      code = `UFI_ISR_FC;
    end

    line_status_reg[0] = (s.rx_cnt != 5'h00);
    line_status_reg[1] = s.oe;
    line_status_reg[3] = s.fe;
    line_status_reg[4] = s.bi;
    // holding empty once the byte reaches the shifter
    line_status_reg[5] = (s.tx_cnt == 5'h00);
    line_status_reg[6] = (s.tx_cnt == 5'h00) & (s.tx_st == ufi_pkg::UFI_IDLE);
    line_status_reg[7] = fifo_en & (s.fe | s.bi);

    // Host reads; data is registered and valid the next cycle
    if (rd) begin
      n.rdata = 8'h00;
      if (enh && (bus.addr == `UFI_A_EFR)) begin
        n.rdata = s.enhanced_feature_reg;
      end else if (enh && (bus.addr == `UFI_A_RES1)) begin
        n.rdata = s.res1;
      end else if (enh && (bus.addr == `UFI_A_RES2)) begin
        n.rdata = s.res2;
      end else if (enh && (bus.addr == `UFI_A_PAU1)) begin
        n.rdata = s.pau1;
      end else if (enh && (bus.addr == `UFI_A_PAU2)) begin
        n.rdata = s.pau2;
      end else if (dlab && (bus.addr == `UFI_A_DATA)) begin
        n.rdata = s.dll;
      end else if (dlab && (bus.addr == `UFI_A_IER)) begin
        n.rdata = s.dlm;
      end else begin
        case (bus.addr)
          `UFI_A_DATA: begin
            n.rdata = s.rx_mem[s.rx_rp];
            pop_rx = (s.rx_cnt != 5'h00);
          end
          `UFI_A_IER: n.rdata = s.int_enable_reg;
          `UFI_A_FCR: begin
            n.rdata = {fifo_en, fifo_en, code};
            // Reading the identity acknowledges a shown transmit or flow-pin source
            if (code == `UFI_ISR_TX) begin
              n.tx_ack = 1'b1;
            end
            if (code == `UFI_ISR_FC) begin
              n.rts_rise = 1'b0;
              n.cts_rise = 1'b0;
            end
          end
          `UFI_A_LCR: n.rdata = s.line_ctrl_reg;
          `UFI_A_MCR: n.rdata = s.modem_ctrl_reg;
          `UFI_A_LSR: begin
            n.rdata = line_status_reg;
            n.oe = 1'b0;
            n.fe = 1'b0;
            n.bi = 1'b0;
          end
          `UFI_A_MSR: begin
            n.rdata = {3'h0, s.mdm_s2[1], 3'h0, s.dcts};
            n.dcts = 1'b0;
          end
          default: n.rdata = s.spr;
        endcase
      end
    end

    // Host writes
    if (wr) begin
      if (enh && (bus.addr == `UFI_A_EFR)) begin
        n.enhanced_feature_reg = bus.wdata;
      end else if (enh && (bus.addr == `UFI_A_RES1)) begin
        n.res1 = bus.wdata;
      end else if (enh && (bus.addr == `UFI_A_RES2)) begin
        n.res2 = bus.wdata;
      end else if (enh && (bus.addr == `UFI_A_PAU1)) begin
        n.pau1 = bus.wdata;
      end else if (enh && (bus.addr == `UFI_A_PAU2)) begin
        n.pau2 = bus.wdata;
      end else if (dlab && (bus.addr == `UFI_A_DATA)) begin
        n.dll = bus.wdata;
      end else if (dlab && (bus.addr == `UFI_A_IER)) begin
        n.dlm = bus.wdata;
      end else begin
        case (bus.addr)
          `UFI_A_DATA: begin
            // stored only when there is room
            push_tx = (s.tx_cnt < depth);
          end
          `UFI_A_IER: n.int_enable_reg = bus.wdata;
          `UFI_A_FCR: begin
            // other bits taken only with enable set
            if (bus.wdata[`UFI_FCR_EN]) begin
              n.fifo_ctrl_reg = {bus.wdata[7:3], 3'h1};
              rx_clr = bus.wdata[`UFI_FCR_RXCLR] | ~fifo_en;
              tx_clr = bus.wdata[`UFI_FCR_TXCLR] | ~fifo_en;
            end else begin
              n.fifo_ctrl_reg = `UFI_RST_FCR;
              rx_clr = fifo_en;
              tx_clr = fifo_en;
            end
          end
          `UFI_A_LCR: n.line_ctrl_reg = bus.wdata;
          `UFI_A_MCR: n.modem_ctrl_reg = bus.wdata;
          `UFI_A_SPR: n.spr = bus.wdata;
          default: n.spr = s.spr;
        endcase
      end
    end

    // Receiver, one bit per 16 sample clocks
    case (s.rx_st)
      ufi_pkg::UFI_IDLE: begin
        if (s.rx_prev && !rxd) begin
          n.rx_st = ufi_pkg::UFI_START;
          n.rx_tick = '0;
        end
      end
      ufi_pkg::UFI_START: begin
        if (tick) begin
          n.rx_tick = s.rx_tick + 4'h1;
        end
        if ((s.rx_tick == `UFI_START_TICKS) && half) begin
          n.rx_tick = '0;
          n.rx_bit = '0;
          n.rx_st = rxd ? ufi_pkg::UFI_IDLE : ufi_pkg::UFI_DATA;
        end
      end
      ufi_pkg::UFI_DATA: begin
        if (tick) begin
          n.rx_tick = s.rx_tick + 4'h1;
          if (s.rx_tick == `UFI_BIT_TICKS) begin
            n.rx_sr = {rxd, s.rx_sr[7:1]};
            n.rx_bit = s.rx_bit + 3'h1;
            if (s.rx_bit == 3'h7) begin
              n.rx_st = ufi_pkg::UFI_STOP;
            end
          end
        end
      end
      ufi_pkg::UFI_STOP: begin
        if (tick && (s.rx_tick == `UFI_BIT_TICKS)) begin
          n.rx_st = ufi_pkg::UFI_IDLE;
          rx_byte = s.rx_sr;
          push_rx = 1'b1;
          n.fe = ~rxd;
          n.bi = ~rxd && (s.rx_sr == 8'h00);
        end else if (tick) begin
          n.rx_tick = s.rx_tick + 4'h1;
        end
      end
      default: n.rx_st = ufi_pkg::UFI_IDLE;
    endcase

    // Transmitter; pulls the next byte when idle
    case (s.tx_st)
      ufi_pkg::UFI_IDLE: begin
        n.tx_line = 1'b1;
        if (tick && (s.tx_cnt != 5'h00)) begin
          n.tx_sr = s.tx_mem[s.tx_rp];
          pop_tx = 1'b1;
          n.tx_st = ufi_pkg::UFI_START;
          n.tx_tick = '0;
          n.tx_line = 1'b0;
        end
      end
      ufi_pkg::UFI_START, ufi_pkg::UFI_DATA: begin
        if (tick) begin
          n.tx_tick = s.tx_tick + 4'h1;
          if (s.tx_tick == `UFI_BIT_TICKS) begin
            n.tx_line = s.tx_sr[0];
            n.tx_sr = {1'b1, s.tx_sr[7:1]};
            n.tx_bit = s.tx_bit + 3'h1;
            if (s.tx_st == ufi_pkg::UFI_START) begin
              n.tx_bit = '0;
              n.tx_st = ufi_pkg::UFI_DATA;
            end else if (s.tx_bit == 3'h7) begin
              n.tx_line = 1'b1;
              n.tx_st = ufi_pkg::UFI_STOP;
            end
          end
        end
      end
      ufi_pkg::UFI_STOP: begin
        if (tick) begin
          n.tx_tick = s.tx_tick + 4'h1;
          if (s.tx_tick == `UFI_BIT_TICKS) begin
            n.tx_st = ufi_pkg::UFI_IDLE;
          end
        end
      end
      default: n.tx_st = ufi_pkg::UFI_IDLE;
    endcase

    // Receive FIFO; a push into a full FIFO is an overrun
    if (push_rx) begin
      if (s.rx_cnt < depth) begin
        n.rx_mem[s.rx_wp] = rx_byte;
        n.rx_wp = s.rx_wp + 4'h1;
      end else begin
        n.oe = 1'b1;
        push_rx = 1'b0;
      end
      // Flow characters compared on arrival; set wins over clear
      if (rx_byte == s.res1) begin
        n.pause_hit = 1'b0;
      end
      if (rx_byte == s.pau1) begin
        n.pause_hit = 1'b1;
      end
    end
    if (pop_rx) begin
      n.rx_rp = s.rx_rp + 4'h1;
    end
    n.rx_cnt = s.rx_cnt + {4'h0, push_rx} - {4'h0, pop_rx};

    // Transmit FIFO
    if (push_tx) begin
      n.tx_mem[s.tx_wp] = bus.wdata;
      n.tx_wp = s.tx_wp + 4'h1;
      n.tx_ack = 1'b0;
    end
    if (pop_tx) begin
      n.tx_rp = s.tx_rp + 4'h1;
    end
    n.tx_cnt = s.tx_cnt + {4'h0, push_tx} - {4'h0, pop_tx};

    if (rx_clr) begin
      n.rx_rp = '0;
      n.rx_wp = '0;
      n.rx_cnt = '0;
    end
    if (tx_clr) begin
      n.tx_rp = '0;
      n.tx_wp = '0;
      n.tx_cnt = '0;
    end

    // Modem edges; an edge in a clearing cycle still sets
    if (s.mdm_s2[1] != s.mdm_prev[1]) begin
      n.dcts = 1'b1;
    end
    if (s.mdm_s2[0] && !s.mdm_prev[0]) begin
      n.rts_rise = 1'b1;
    end
    if (s.mdm_s2[1] && !s.mdm_prev[1]) begin
      n.cts_rise = 1'b1;
    end
    if (push_rx && ~rxd) begin
      n.fe = 1'b1;
    end

    n.irq = (code != `UFI_ISR_NONE);
    if (fifo_en && s.fifo_ctrl_reg[`UFI_FCR_DMA]) begin
      // transmit request while any slot is free
      n.tx_dma_n = ~(s.tx_cnt < `UFI_DEPTH);
      // receive request from trigger until empty
      if (rx_trig) begin
        n.rx_dma = 1'b1;
      end else if (s.rx_cnt == 5'h00) begin
        n.rx_dma = 1'b0;
      end
      n.rx_dma_n = ~n.rx_dma;
    end else begin
      n.tx_dma_n = (s.tx_cnt != 5'h00);
      n.rx_dma = 1'b0;
      n.rx_dma_n = (s.rx_cnt == 5'h00);
    end
  end

  // All state in one record, reset to constants
  always_ff @(posedge clk or negedge rst_q[1]) begin
    if (!rst_q[1]) begin
      s <= ufi_pkg::ufi_init();
    end else begin
      s <= n;
    end
  end

  assign rdata = s.rdata;
  assign tx_out = s.tx_line;
  assign irq_out = s.irq;
  assign tx_dma_request_n = s.tx_dma_n;
  assign rx_dma_request_n = s.rx_dma_n;
endmodule

// [test/ufi_core_props.sv]
// Port-level assertions for the UART FIFO and interrupt control core
`timescale 1ns/1ps
module ufi_core_props (
  input wire logic clk,
  input wire logic arst_n,
  input wire ufi_pkg::ufi_bus_type bus,
  input wire logic rx_in,
  input wire logic rts_in,
  input wire logic cts_in,
  input wire logic [7:0] rdata,
  input wire logic tx_out,
  input wire logic irq_out,
  input wire logic tx_dma_request_n,
  input wire logic rx_dma_request_n
);
  logic [7:0] line_ctrl_reg, int_enable_reg, enhanced_feature_reg, dll, spr, pau2, exp7;
  logic fen, dma1, wr, rd, lsr_rd, mode0;

  // Access strobes and the register set each one lands in
  assign wr = bus.cs && bus.wr;
  assign rd = bus.cs && bus.rd;
  assign lsr_rd = rd && bus.addr == 3'h5 && line_ctrl_reg != 8'hbf;
  assign mode0 = !(fen && dma1);
  assign exp7 = (line_ctrl_reg == 8'hbf) ? pau2 : spr;

  // Shadow of host-written control state; only bus writes change it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      line_ctrl_reg <= 8'h00;
      int_enable_reg <= 8'h00;
      enhanced_feature_reg <= 8'h00;
      dll <= 8'h00;
      spr <= 8'hff;
      pau2 <= 8'h00;
      fen <= 1'b0;
      dma1 <= 1'b0;
    end else if (wr) begin
      case (bus.addr)
        3'h0: if (line_ctrl_reg[7]) dll <= bus.wdata;
        3'h1: if (!line_ctrl_reg[7]) int_enable_reg <= bus.wdata;
        3'h2: begin
          if (line_ctrl_reg == 8'hbf) enhanced_feature_reg <= bus.wdata;
          if (line_ctrl_reg != 8'hbf) fen <= bus.wdata[0];
          if (line_ctrl_reg != 8'hbf) dma1 <= bus.wdata[0] && bus.wdata[3];
        end
        3'h3: line_ctrl_reg <= bus.wdata;
        3'h7: begin
          if (line_ctrl_reg == 8'hbf) pau2 <= bus.wdata;
          else spr <= bus.wdata;
        end
        default: ;
      endcase
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  dll_read_a: assert property (
    rd && bus.addr == 3'h0 && line_ctrl_reg[7] |=> rdata == $past(dll))
    else $error("divisor low byte read back wrong");
  enh_map_a: assert property (
    rd && bus.addr == 3'h7 |=> rdata == $past(exp7))
    else $error("address seven read from the wrong register set");
  irq_masked_a: assert property (
    int_enable_reg == 8'h00 && $past(int_enable_reg) == 8'h00 |-> !irq_out)
    else $error("interrupt raised with every source disabled");
  ident_fifo_a: assert property (
    rd && bus.addr == 3'h2 && line_ctrl_reg != 8'hbf |=>
    rdata[7:6] == {2{$past(fen)}})
    else $error("ident FIFO bits do not follow the enable");
  lsr_order_a: assert property (
    lsr_rd |=> (!rdata[6] || rdata[5]) && (!rdata[7] || $past(fen)))
    else $error("line status bits inconsistent");
  dready_a: assert property (
    lsr_rd && mode0 ##1 $stable(rx_dma_request_n) |->
    rdata[0] == !rx_dma_request_n)
    else $error("data ready disagrees with receive request");
  thre_a: assert property (
    lsr_rd && mode0 ##1 $stable(tx_dma_request_n) |->
    rdata[5] == !tx_dma_request_n)
    else $error("holding empty disagrees with transmit request");
  flow_irq_a: assert property (
    enhanced_feature_reg[4] && ($rose(rts_in) && int_enable_reg[6] || $rose(cts_in) && int_enable_reg[7])
    |-> ##[1:8] irq_out)
    else $error("no interrupt after enabled flow pin rise");
  rdata_hold_a: assert property (
    !rd |=> $stable(rdata))
    else $error("read data moved without a read");

  rx_ready_c: cover property ($fell(rx_dma_request_n));
  fifo_irq_c: cover property (fen && $rose(irq_out));
  tx_full_c: cover property (dma1 && $rose(tx_dma_request_n));
endmodule

// [test/ufi_host.sv]
// Host processor model: register bus master for the UART core
`timescale 1ns/1ps
module ufi_host (
  input wire logic clk,
  input wire logic [7:0] rdata,
  output ufi_pkg::ufi_bus_type bus
);
  // Extra idle cycles after each access; non-zero models a slow host
  int gap = 0;

  initial begin
    bus = '0;
  end

  // Drive after a falling edge, hold over the taking edge, then release
  task automatic access(input logic w, input logic [2:0] a,
                        input logic [7:0] d);
    @(negedge clk);
    bus.addr = a;
    bus.wdata = d;
    bus.wr = w;
    bus.rd = !w;
    bus.cs = 1'b1;
    @(negedge clk);
    bus.cs = 1'b0;
    bus.rd = 1'b0;
    bus.wr = 1'b0;
    // Released lines flip so stale values cannot pass for driven ones
    bus.addr = ~a;
    bus.wdata = ~d;
    repeat (gap) @(negedge clk);
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    access(1'b1, a, d);
  endtask

  // Read data is registered, so it is taken a cycle after release and any idle gap
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    access(1'b0, a, 8'h00);
    @(negedge clk);
    d = rdata;
  endtask

  task automatic set_map(input logic [7:0] v);
    wr(3'h3, v);
  endtask

  // enable bit rides with each FIFO control write that turns FIFOs on; off writes zero
  task automatic set_fifo(input logic on, input logic [7:0] v);
    wr(3'h2, on ? (v | 8'h01) : 8'h00);
  endtask
endmodule

// [test/uart_fifo_interrupt_control_tb.sv]
// Self-checking bench for the UART FIFO and interrupt control core
`timescale 1ns/1ps
module uart_fifo_interrupt_control_tb;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic rx_in = 1'b1;
  logic rts_in = 1'b0;
  logic cts_in = 1'b0;
  logic [7:0] rdata, v;
  logic tx_out, irq_out, tx_dma_request_n, rx_dma_request_n;
  ufi_pkg::ufi_bus_type bus;
  logic [2:0] enh_a [5] = '{3'h2, 3'h4, 3'h5, 3'h6, 3'h7};
  logic [7:0] enh_v [5] = '{8'h10, 8'h21, 8'h22, 8'h23, 8'h24};
  logic [7:0] ier_v [3] = '{8'h00, 8'h40, 8'h80};
  int fails = 0;
  int n_checks = 0;
  int i, k;

  always #4 clk = ~clk;

  ufi_host host (.clk(clk), .rdata(rdata), .bus(bus));
  ufi_core uut (.clk(clk), .arst_n(arst_n), .bus(bus), .rx_in(rx_in),
    .rts_in(rts_in), .cts_in(cts_in), .rdata(rdata), .tx_out(tx_out),
    .irq_out(irq_out), .tx_dma_request_n(tx_dma_request_n),
    .rx_dma_request_n(rx_dma_request_n));

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic rchk(input logic [2:0] a, input logic [7:0] exp);
    host.rd(a, v);
    chk(v, exp);
  endtask

  // One tick per clock with divisor 1: start, data LSB first, stop
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int j = 0; j < 10; j++) begin
      rx_in = f[j];
      repeat (16) @(negedge clk);
    end
    repeat (10) @(negedge clk);
  endtask

  initial begin
    repeat (2) @(negedge clk);
    arst_n = 1'b1;
    repeat (3) @(negedge clk);
    rchk(3'h1, 8'h00);
    rchk(3'h2, 8'h01);
    rchk(3'h5, 8'h60);
    rchk(3'h7, 8'hff);
    $display("test reset values done");
    // Divisor latch, then the enhanced set, then back to general
    // A slow host here shows that idle gaps change nothing
    host.gap = 1;
    host.set_map(8'h80);
    host.wr(3'h0, 8'h01);
    rchk(3'h0, 8'h01);
    host.set_map(8'hbf);
    for (i = 0; i < 5; i++) rchk(enh_a[i], 8'h00);
    for (i = 0; i < 5; i++) host.wr(enh_a[i], enh_v[i]);
    for (i = 0; i < 5; i++) rchk(enh_a[i], enh_v[i]);
    host.set_map(8'h03);
    rchk(3'h7, 8'hff);
    rchk(3'h2, 8'h01);
    host.gap = 0;
    $display("test register sets done");
    // Transmit one byte and watch it on the line
    host.wr(3'h0, 8'ha5);
    k = 0;
    while (tx_out !== 1'b0 && k < 50) begin
      @(negedge clk);
      k++;
    end
    if (k == 50) begin
      fails++;
      complete_run();
    end
    repeat (7) @(negedge clk);
    chk({7'h0, tx_out}, 8'h00);
    for (i = 0; i < 8; i++) begin
      repeat (16) @(negedge clk);
      chk({7'h0, tx_out}, (8'ha5 >> i) & 8'h01);
    end
    repeat (16) @(negedge clk);
    chk({7'h0, tx_out}, 8'h01);
    repeat (16) @(negedge clk);
    rchk(3'h5, 8'h60);
    $display("test transmit done");
    // Receive one byte without FIFOs
    send(8'h5a);
    chk({7'h0, rx_dma_request_n}, 8'h00);
    rchk(3'h5, 8'h61);
    rchk(3'h0, 8'h5a);
    rchk(3'h5, 8'h60);
    chk({7'h0, rx_dma_request_n}, 8'h01);
    chk({7'h0, tx_dma_request_n}, 8'h00);
    // A short low pulse is dropped, a long one frames all ones
    for (i = 4; i < 16; i += 8) begin
      rx_in = 1'b0;
      repeat (i) @(negedge clk);
      rx_in = 1'b1;
      repeat (200) @(negedge clk);
      rchk(3'h5, i == 4 ? 8'h60 : 8'h61);
    end
    rchk(3'h0, 8'hff);
    $display("test receive done");
    // FIFO on, trigger four, receive interrupt enabled
    host.set_fifo(1'b1, 8'h40);
    host.wr(3'h1, 8'h01);
    for (i = 1; i < 5; i++) begin
      send(8'(i));
      chk({7'h0, irq_out}, i == 4 ? 8'h01 : 8'h00);
    end
    rchk(3'h2, 8'hc4);
    rchk(3'h0, 8'h01);
    chk({7'h0, irq_out}, 8'h00);
    rchk(3'h2, 8'hc1);
    // Block mode with receive clear; three bytes stay queued until now
    host.set_fifo(1'b1, 8'h4a);
    repeat (2) @(negedge clk);
    chk({7'h0, rx_dma_request_n}, 8'h01);
    rchk(3'h5, 8'h60);
    for (i = 0; i < 4; i++) begin
      send(8'h10 + 8'(i));
      chk({7'h0, rx_dma_request_n}, i == 3 ? 8'h00 : 8'h01);
    end
    for (i = 0; i < 4; i++) begin
      chk({7'h0, rx_dma_request_n}, 8'h00);
      rchk(3'h0, 8'h10 + 8'(i));
    end
    chk({7'h0, rx_dma_request_n}, 8'h01);
    $display("test receive FIFO done");
    // Fill the transmit FIFO, then clear it under a busy shifter
    for (i = 0; i < 17; i++) host.wr(3'h0, 8'(i));
    @(negedge clk);
    chk({7'h0, tx_dma_request_n}, 8'h01);
    host.set_fifo(1'b1, 8'h4c);
    @(negedge clk);
    chk({7'h0, tx_dma_request_n}, 8'h00);
    rchk(3'h5, 8'h20);
    repeat (200) @(negedge clk);
    rchk(3'h5, 8'h60);
    $display("test transmit FIFO done");
    // Flow pin rises: masked, then request, then clear to send
    for (i = 0; i < 3; i++) begin
      host.wr(3'h1, ier_v[i]);
      {cts_in, rts_in} = (i == 2) ? 2'b10 : 2'b01;
      repeat (8) @(negedge clk);
      chk({7'h0, irq_out}, i == 0 ? 8'h00 : 8'h01);
      if (i > 0) rchk(3'h2, 8'he0);
      {cts_in, rts_in} = 2'b00;
      repeat (8) @(negedge clk);
      chk({7'h0, irq_out}, 8'h00);
    end
    // Modem delta left from the pin toggles, then status read clears it
    host.wr(3'h1, 8'h08);
    rchk(3'h2, 8'hc0);
    rchk(3'h6, 8'h01);
    rchk(3'h2, 8'hc1);
    // Transmit empty source, acknowledged by the identity read
    host.wr(3'h1, 8'h22);
    rchk(3'h2, 8'hc2);
    chk({7'h0, irq_out}, 8'h00);
    // Pause character raises its source, resume character drops it
    send(8'h23);
    chk({7'h0, irq_out}, 8'h01);
    rchk(3'h2, 8'hd0);
    send(8'h21);
    chk({7'h0, irq_out}, 8'h00);
    host.set_fifo(1'b0, 8'h00);
    rchk(3'h2, 8'h01);
    $display("test flow interrupts done");
    complete_run();
  end
endmodule

bind ufi_core ufi_core_props ufi_core_props_i (.clk(clk), .arst_n(arst_n),
  .bus(bus), .rx_in(rx_in), .rts_in(rts_in), .cts_in(cts_in),
  .rdata(rdata), .tx_out(tx_out), .irq_out(irq_out),
  .tx_dma_request_n(tx_dma_request_n), .rx_dma_request_n(rx_dma_request_n));
